// file: hw/bstap_ctrl.v
// Purpose: boundary scan test access port controller
// Assumes: test pins sampled by clk_in, test clock far slower than clk_in
// Notes: rising and falling test clock edges are found from synced samples
`timescale 1ns/100ps
`include "bstap_defs.vh"
module bstap_ctrl #(
	parameter BSR_W = 8,
	parameter [31:0] ID_CODE = 32'h00000001 // arbitrary value
)(
	// system clock and reset
	input wire clk_in,
	input wire nrst_in,
	// test pins
	input wire test_clock_pin_in,
	input wire test_reset_low_pin_in,
	input wire test_serial_in_in,
	input wire test_mode_select_in,
	output reg test_serial_out_out,
	output reg test_serial_out_oe_out,
	// boundary cells toward the device pins
	input wire [BSR_W-1:0] bsr_pins_in,
	input wire [BSR_W-1:0] sys_pins_in,
	input wire [BSR_W-1:0] sys_oe_in,
	output wire [BSR_W-1:0] pins_out,
	output wire [BSR_W-1:0] pins_oe_out,
	// status
	output reg [`BSTAP_IR_W-1:0] instr_out,
	output reg [31:0] id_latch_out
);
	// one-hot states: reset, idle and the data column
	localparam [15:0] S_TLR = 16'h0001;
	localparam [15:0] S_RTI = 16'h0002;
	localparam [15:0] S_SDR = 16'h0004;
	localparam [15:0] S_CDR = 16'h0008;
	localparam [15:0] S_SHD = 16'h0010;
	localparam [15:0] S_E1D = 16'h0020;
	localparam [15:0] S_PSD = 16'h0040;
	localparam [15:0] S_E2D = 16'h0080;
	localparam [15:0] S_UDR = 16'h0100;
	// one-hot states: the instruction column
	localparam [15:0] S_SIR = 16'h0200;
	localparam [15:0] S_CIR = 16'h0400;
	localparam [15:0] S_SHI = 16'h0800;
	localparam [15:0] S_E1I = 16'h1000;
	localparam [15:0] S_PSI = 16'h2000;
	localparam [15:0] S_E2I = 16'h4000;
	localparam [15:0] S_UIR = 16'h8000;

	reg [15:0] state;
	reg [15:0] next_state;
	reg [`BSTAP_IR_W-1:0] ir_shift;
	reg [31:0] id_shift;
	reg bypass_bit;
	reg [BSR_W-1:0] bsr_shift;
	reg [BSR_W-1:0] bsr_latch;
	// two-flop synchronisers and edge history
	reg [1:0] tck_s;
	reg [1:0] trst_s;
	reg [1:0] tdi_s;
	reg [1:0] tms_s;
	reg tck_d;
	wire tck_rise;
	wire tck_fall;
	wire trst_n;
	wire tms;
	wire tdi;

	assign tck_rise = tck_s[1] & ~tck_d;
	assign tck_fall = ~tck_s[1] & tck_d;
	assign trst_n = trst_s[1];
	assign tms = tms_s[1];
	assign tdi = tdi_s[1];

	// serial path selection by current instruction
	function [1:0] bstap_dr_sel;
		input [`BSTAP_IR_W-1:0] op;
		begin
			case (op)
				`BSTAP_OP_EXTEST: bstap_dr_sel = 2'h1;
				`BSTAP_OP_SAMPLE: bstap_dr_sel = 2'h1;
				`BSTAP_OP_IDCODE: bstap_dr_sel = 2'h2;
				default: bstap_dr_sel = 2'h0; // bypass, highz, clamp
			endcase
		end
	endfunction

	// synchronise test pins
	always @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			tck_s <= 2'h0;
			trst_s <= 2'h0;
			tdi_s <= 2'h0;
			tms_s <= 2'h3;
			tck_d <= 1'b0;
		end
		else
		begin
			tck_s <= {tck_s[0], test_clock_pin_in};
			trst_s <= {trst_s[0], test_reset_low_pin_in};
			tdi_s <= {tdi_s[0], test_serial_in_in};
			tms_s <= {tms_s[0], test_mode_select_in};
			tck_d <= tck_s[1];
		end
	end

	// next-state table
	always @*
	begin
		case (state)
			S_TLR: next_state = tms ? S_TLR : S_RTI;
			S_RTI: next_state = tms ? S_SDR : S_RTI;
			S_SDR: next_state = tms ? S_SIR : S_CDR;
			S_CDR: next_state = tms ? S_E1D : S_SHD;
			S_SHD: next_state = tms ? S_E1D : S_SHD;
			S_E1D: next_state = tms ? S_UDR : S_PSD;
			S_PSD: next_state = tms ? S_E2D : S_PSD;
			S_E2D: next_state = tms ? S_UDR : S_SHD;
			S_UDR: next_state = tms ? S_SDR : S_RTI;
			S_SIR: next_state = tms ? S_TLR : S_CIR;
			S_CIR: next_state = tms ? S_E1I : S_SHI;
			S_SHI: next_state = tms ? S_E1I : S_SHI;
			S_E1I: next_state = tms ? S_UIR : S_PSI;
			S_PSI: next_state = tms ? S_E2I : S_PSI;
			S_E2I: next_state = tms ? S_UIR : S_SHI;
			S_UIR: next_state = tms ? S_SDR : S_RTI;
			default: next_state = S_TLR;
		endcase
	end

	// state and shift registers on rising test clock edge
	always @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			state <= S_TLR;
			ir_shift <= 3'h0;
			id_shift <= 32'h00000000;
			bypass_bit <= 1'b0;
			bsr_shift <= {BSR_W{1'b0}};
		end
		else if (!trst_n)
			state <= S_TLR;
		else if (tck_rise)
		begin
			state <= next_state;
			// capture states load, shift states move toward output
			// every other state, idle and select included, leaves
			// the registers alone
			if (state == S_CIR)
				ir_shift <= `BSTAP_IR_CAPTURE;
			else if (state == S_SHI)
				ir_shift <= {tdi, ir_shift[`BSTAP_IR_W-1:1]};
			if (state == S_CDR)
			begin
				case (bstap_dr_sel(instr_out))
					2'h1: bsr_shift <= bsr_pins_in;
					2'h2: id_shift <= ID_CODE;
					default: bypass_bit <= 1'b0;
				endcase
			end
			else if (state == S_SHD)
			begin
				case (bstap_dr_sel(instr_out))
					2'h1: bsr_shift <= {tdi, bsr_shift[BSR_W-1:1]};
					2'h2: id_shift <= {tdi, id_shift[31:1]};
					default: bypass_bit <= tdi;
				endcase
			end
		end
	end

	// data register chosen by the current instruction
	wire [1:0] dr_sel;
	assign dr_sel = bstap_dr_sel(instr_out);

	// current instruction: held at identify while in the reset state,
	// so a tester that only pulses mode-select still reads the id first
	always @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			instr_out <= `BSTAP_OP_IDCODE;
		else if (state == S_TLR || !trst_n)
			instr_out <= `BSTAP_OP_IDCODE;
		else if (tck_fall && state == S_UIR)
			instr_out <= ir_shift;
	end

	// update-dr falling edge copies shift paths into the parallel
	// latches; the pins never see bits while they are shifting
	always @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			id_latch_out <= 32'h00000000;
			bsr_latch <= {BSR_W{1'b0}};
		end
		else if (tck_fall && state == S_UDR)
		begin
			if (dr_sel == 2'h1)
				bsr_latch <= bsr_shift;
			if (dr_sel == 2'h2)
				id_latch_out <= id_shift;
		end
	end

	// serial output moves only on the falling edge, so the bit is
	// settled for the whole high phase that the tester samples in
	always @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			test_serial_out_out <= 1'b0;
			test_serial_out_oe_out <= 1'b0;
		end
		else if (tck_fall)
		begin
			// driven only in the two shift states
			test_serial_out_oe_out <= (state == S_SHD) || (state == S_SHI);
			if (state == S_SHI)
				test_serial_out_out <= ir_shift[0];
			else if (dr_sel == 2'h1)
				test_serial_out_out <= bsr_shift[0];
			else if (dr_sel == 2'h2)
				test_serial_out_out <= id_shift[0];
			else
				test_serial_out_out <= bypass_bit;
		end
	end

	// boundary drive decode; in the reset state system logic owns pins
	wire test_mode;
	wire drive_bsr;
	wire float_pins;
	assign test_mode = (state != S_TLR);
	assign drive_bsr = test_mode && (instr_out == `BSTAP_OP_EXTEST ||
		instr_out == `BSTAP_OP_CLAMP);
	assign float_pins = test_mode && (instr_out == `BSTAP_OP_HIGHZ);

	// pin muxing: system logic runs except under extest, clamp or highz
	assign pins_out = drive_bsr ? bsr_latch : sys_pins_in;
	assign pins_oe_out = float_pins ? {BSR_W{1'b0}} :
		drive_bsr ? {BSR_W{1'b1}} : sys_oe_in;
endmodule // bstap_ctrl

// file: hw/bstap_defs.vh
// Purpose: constants for the boundary scan test access port
// Assumes: included by bstap_ctrl.v
// Notes: codes and states are one-hot or binary as commented
`ifndef BSTAP_DEFS_VH
`define BSTAP_DEFS_VH
// instruction width and codes
`define BSTAP_IR_W 3
`define BSTAP_OP_EXTEST 3'h0
`define BSTAP_OP_HIGHZ 3'h2
`define BSTAP_OP_CLAMP 3'h3
`define BSTAP_OP_SAMPLE 3'h4
`define BSTAP_OP_IDCODE 3'h6
`define BSTAP_OP_BYPASS 3'h7
// fixed value loaded at instruction capture
`define BSTAP_IR_CAPTURE 3'h1
// identification register width
`define BSTAP_ID_W 32
`endif

// file: sim/bstap_checker.sv
// Purpose: port assertions for bstap_ctrl
// Assumes: test pins are slow against clk_in
// Notes: six cycles of high test clock means no edge in flight
`timescale 1ns/100ps
module bstap_checker #(parameter BSR_W = 8)(
	// clock and reset
	input wire clk_in,
	input wire nrst_in,
	// test pins
	input wire test_clock_pin_in,
	input wire test_reset_low_pin_in,
	input wire test_serial_out_out,
	input wire test_serial_out_oe_out,
	// pins and status
	input wire [BSR_W-1:0] sys_pins_in,
	input wire [BSR_W-1:0] sys_oe_in,
	input wire [BSR_W-1:0] pins_out,
	input wire [BSR_W-1:0] pins_oe_out,
	input wire [2:0] instr_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	// quiet windows: test clock held high, test reset held low
	sequence s_hi; (test_clock_pin_in && test_reset_low_pin_in)[*6]; endsequence
	sequence s_trst; (!test_reset_low_pin_in)[*6]; endsequence
	property p_rst; $rose(nrst_in) |-> instr_out == 3'h6; endproperty
	property p_trst; s_trst |-> instr_out == 3'h6; endproperty
	property p_ir; s_hi |-> $stable(instr_out) || instr_out == 3'h6; endproperty
	property p_so; s_hi |-> $stable(test_serial_out_out); endproperty
	property p_oe; s_hi |-> $stable(test_serial_out_oe_out); endproperty
	property p_sys; instr_out inside {3'h4, 3'h6, 3'h7} |->
		pins_out == sys_pins_in && pins_oe_out == sys_oe_in; endproperty
	property p_hz; instr_out == 3'h2 |-> pins_oe_out == '0; endproperty
	property p_clamp; s_hi ##0 instr_out == 3'h3 |-> $stable(pins_out); endproperty
	a_rst: assert property (p_rst) else $error("no identify at reset");
	a_trst: assert property (p_trst) else $error("pin reset missed");
	a_ir: assert property (p_ir) else $error("instr moved");
	a_so: assert property (p_so) else $error("serial out moved");
	a_oe: assert property (p_oe) else $error("serial enable moved");
	a_sys: assert property (p_sys) else $error("pins not system");
	a_hz: assert property (p_hz) else $error("pins driven");
	a_clamp: assert property (p_clamp) else $error("clamp moved");
endmodule // bstap_checker

bind bstap_ctrl bstap_checker #(.BSR_W(BSR_W)) u_bstap_checker (.clk_in,
	.nrst_in, .test_clock_pin_in, .test_reset_low_pin_in,
	.test_serial_out_out, .test_serial_out_oe_out, .sys_pins_in,
	.sys_oe_in, .pins_out, .pins_oe_out, .instr_out);

// file: sim/bstap_ctrl_tb.sv
// Purpose: self-checking bench for bstap_ctrl
// Assumes: tester model owns the test pins
// Notes: scans shift lsb first
`timescale 1ns/100ps
`include "bstap_defs.vh"
module bstap_ctrl_tb;
	localparam [31:0] ID = 32'h5A3C0F01; // arbitrary value
	localparam [7:0] SP = 8'h96;
	logic clk_in, nrst_in, tck, trst, tdi, tms, so, oe;
	logic [7:0] pins, poe;
	logic [2:0] instr;
	logic [31:0] idl, d;
	int num_errors = 0, n_checks = 0;
	// device and tester
	bstap_ctrl #(.BSR_W(8), .ID_CODE(ID)) u_bstap_ctrl (.clk_in(clk_in),
		.nrst_in(nrst_in), .test_clock_pin_in(tck),
		.test_reset_low_pin_in(trst), .test_serial_in_in(tdi),
		.test_mode_select_in(tms), .test_serial_out_out(so),
		.test_serial_out_oe_out(oe), .bsr_pins_in(8'h3C), .sys_pins_in(SP),
		.sys_oe_in(8'hF0), .pins_out(pins), .pins_oe_out(poe),
		.instr_out(instr), .id_latch_out(idl));
	bstap_tester u_bstap_tester (.clk_in(clk_in), .test_serial_out_out(so),
		.test_clock_pin_in(tck), .test_reset_low_pin_in(trst),
		.test_serial_in_in(tdi), .test_mode_select_in(tms));
	// 20 MHz clock
	initial
	begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end
	task check(input logic [31:0] seen, input logic [31:0] exp);
	begin
		n_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	end
	endtask
	task final_report();
	begin
		$display("checks=%0d errors=%0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	end
	endtask
	// instruction scan from idle, back to idle
	task load(input logic [2:0] op);
	begin
		u_bstap_tester.walk(8'h03, 4);
		u_bstap_tester.scan({29'h0, op}, 3, d);
		check(d, `BSTAP_IR_CAPTURE);
		u_bstap_tester.walk(8'h0C, 5);
		check(instr, op);
		check(oe, 1'b0);
	end
	endtask
	task t_idcode();
	begin
		check(instr, `BSTAP_OP_IDCODE);
		check(pins, SP);
		u_bstap_tester.walk(8'h02, 4);
		u_bstap_tester.scan(32'hC3A55A0F, 32, d);
		check(d, ID);
		u_bstap_tester.walk(8'h01, 2);
		check(idl, 32'hC3A55A0F);
		$display("idcode done");
	end
	endtask
	task t_ops();
		logic [2:0] ops [6];
	begin
		ops = '{`BSTAP_OP_EXTEST, `BSTAP_OP_HIGHZ, `BSTAP_OP_CLAMP,
			`BSTAP_OP_SAMPLE, `BSTAP_OP_IDCODE, `BSTAP_OP_BYPASS};
		foreach (ops[i])
		begin
			load(ops[i]);
			if (ops[i] == `BSTAP_OP_EXTEST)
			begin
				u_bstap_tester.walk(8'h01, 3);
				u_bstap_tester.scan(32'h69, 8, d);
				check(d, 32'h3C);
				u_bstap_tester.walk(8'h01, 2);
				check(pins, 8'h69);
				check(poe, 8'hFF);
			end
			if (ops[i] == `BSTAP_OP_HIGHZ)
				check(poe, 8'h00);
			if (ops[i] == `BSTAP_OP_CLAMP)
				check(pins, 8'h69);
			if (ops[i] == `BSTAP_OP_SAMPLE)
				check(pins, SP);
		end
		$display("opcodes done");
	end
	endtask
	// bypass scan split by a pause
	task t_bypass();
	begin
		u_bstap_tester.walk(8'h01, 3);
		u_bstap_tester.scan(32'hA, 4, d);
		check(d, 32'h4);
		u_bstap_tester.walk(8'h04, 4);
		u_bstap_tester.scan(32'h5, 4, d);
		check(d, 32'hB);
		u_bstap_tester.walk(8'h01, 2);
		$display("bypass done");
	end
	endtask
	task t_resets();
	begin
		u_bstap_tester.walk(8'h1F, 5);
		check(instr, `BSTAP_OP_IDCODE);
		u_bstap_tester.walk(8'h00, 1);
		load(`BSTAP_OP_HIGHZ);
		u_bstap_tester.pin_reset();
		check(instr, `BSTAP_OP_IDCODE);
		$display("resets done");
	end
	endtask
	// hang guard
	initial
	begin
		#2000000;
		num_errors++;
		final_report();
	end
	// main sequence
	initial
	begin
		nrst_in = 1'b0;
		repeat (6) @(posedge clk_in);
		#1 nrst_in = 1'b1;
		repeat (4) @(posedge clk_in);
		#1;
		t_idcode();
		t_ops();
		t_bypass();
		t_resets();
		final_report();
	end
endmodule // bstap_ctrl_tb

// file: sim/bstap_tester.sv
// Purpose: external boundary scan tester model
// Assumes: calls start just after a clk_in rising edge
// Notes: test clock idles low, serial out sampled before each fall
`timescale 1ns/100ps
module bstap_tester (
	// system clock
	input wire clk_in,
	// five test pins
	input wire test_serial_out_out,
	output logic test_clock_pin_in,
	output logic test_reset_low_pin_in,
	output logic test_serial_in_in,
	output logic test_mode_select_in
);
	// idle levels
	initial
	begin
		test_clock_pin_in = 1'b0;
		test_reset_low_pin_in = 1'b1;
		test_serial_in_in = 1'b0;
		test_mode_select_in = 1'b1;
	end
	// one 400 ns test clock period
	task step(input logic m, input logic di, output logic b);
	begin
		test_mode_select_in = m;
		test_serial_in_in = di;
		#200 test_clock_pin_in = 1'b1;
		#198 b = test_serial_out_out;
		#2 test_clock_pin_in = 1'b0;
	end
	endtask
	// mode sequence, lsb first
	task walk(input logic [7:0] m, input int n);
		logic b;
	begin
		for (int i = 0; i < n; i++)
			step(m[i], 1'b0, b);
	end
	endtask
	// n bits lsb first, last one leaves the shift state
	task scan(input logic [31:0] din, input int n, output logic [31:0] q);
		logic b;
	begin
		q = '0;
		for (int i = 0; i < n; i++)
		begin
			step(i == n - 1, din[i], b);
			q[i] = b;
		end
	end
	endtask
	// pulse the test reset pin
	task pin_reset();
	begin
		test_reset_low_pin_in = 1'b0;
		#500 test_reset_low_pin_in = 1'b1;
	end
	endtask
endmodule // bstap_tester
